// ==== dv/pds_nv_model.sv ====
// Purpose: Nonvolatile writer model answering commit requests
// Assumes: NV request held until acknowledged
// Notes: Delay input sets prompt or slow answers
`timescale 1ns/1ps
module pds_nv_model (
	input wire logic clk,
	input wire logic req,
	input wire logic [5:0] addr,
	input wire logic [31:0] data,
	input wire logic [7:0] delay,
	output logic done,
	output int commits,
	output logic [5:0] last_addr,
	output logic [31:0] last_data
);
	int cnt;
	initial begin
		done = 1'b0;
		commits = 0;
		cnt = 0;
		last_addr = 6'h00;
		last_data = 32'h00000000;
	end
	// ==========================================
	// Commit answer after a programmable wait
	always @(posedge clk) begin
		if (done || !req) begin
			done <= 1'b0;
			cnt <= 0;
		end else if (cnt >= int'(delay)) begin
			done <= 1'b1;
			last_addr <= addr;
			last_data <= data;
			commits <= commits + 1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// ==== dv/pds_store_tb.sv ====
// Purpose: Self-checking bench for the parameter dictionary store
// Assumes: CHANNELS=2, SUBS=2
// Notes: Random data from a fixed xorshift seed
`timescale 1ns/1ps
module pds_store_tb;
	import pds_pkg::*;
	logic CLK_SYS, RST_N, REQ_VALID, REQ_WRITE, NV_DONE, RSP_VALID, RSP_ABORT, BUSY, NV_REQ;
	logic SUPPRESS_NONVOLATILE_SAVE, ab;
	logic [15:0] REQ_INDEX;
	logic [7:0] REQ_SUBINDEX, nv_delay;
	logic [31:0] REQ_WDATA, IN_PDO_DATA, RSP_DATA, NV_DATA, OUT_PDO_DATA, last_data, got, r, d, seed;
	logic [5:0] NV_ADDR, last_addr, ch;
	int commits, c, error_cnt, samples_checked;
	logic [15:0] bad_i [4] = '{16'h5000, 16'h8020, 16'h8010, 16'hffff};
	logic [7:0] bad_s [4] = '{8'h00, 8'h00, 8'h02, 8'hff};
	logic [31:0] bad_e [4] = '{ABORT_NO_OBJECT, ABORT_NO_OBJECT, ABORT_NO_SUB, ABORT_NO_OBJECT};
	pds_store #(.CHANNELS(2), .SUBS(2)) u_pds_store (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
		.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_INDEX(REQ_INDEX),
		.REQ_SUBINDEX(REQ_SUBINDEX), .REQ_WDATA(REQ_WDATA), .IN_PDO_DATA(IN_PDO_DATA),
		.NV_DONE(NV_DONE), .RSP_VALID(RSP_VALID), .RSP_ABORT(RSP_ABORT), .RSP_DATA(RSP_DATA),
		.BUSY(BUSY), .SUPPRESS_NONVOLATILE_SAVE(SUPPRESS_NONVOLATILE_SAVE), .NV_REQ(NV_REQ),
		.NV_ADDR(NV_ADDR), .NV_DATA(NV_DATA), .OUT_PDO_DATA(OUT_PDO_DATA));
	pds_nv_model u_pds_nv_model (.clk(CLK_SYS), .req(NV_REQ), .addr(NV_ADDR), .data(NV_DATA),
		.delay(nv_delay), .done(NV_DONE), .commits(commits), .last_addr(last_addr),
		.last_data(last_data));
	// ==========================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] chidx(input logic [15:0] base, input logic [5:0] e);
		return base + {11'h000, e[5:1]};
	endfunction
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic idle();
		int n;
		n = 0;
		while ((NV_REQ !== 1'b0 || BUSY !== 1'b0) && n < 400) begin
			@(posedge CLK_SYS);
			#1;
			n++;
		end
		if (n >= 400) begin
			error_cnt++;
			end_of_test();
		end
	endtask
	task automatic drive(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] dd);
		@(posedge CLK_SYS);
		REQ_VALID <= 1'b1;
		REQ_WRITE <= w;
		REQ_INDEX <= i;
		REQ_SUBINDEX <= s;
		REQ_WDATA <= dd;
		@(posedge CLK_SYS);
		REQ_VALID <= 1'b0;
		#1;
	endtask
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] dd);
		idle();
		drive(w, i, s, dd);
		chk1(RSP_VALID, 1'b1);
		ab = RSP_ABORT;
		got = RSP_DATA;
	endtask
	initial begin
		CLK_SYS = 1'b0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	// ==========================================
	// Main sequence
	initial begin
		RST_N = 1'b0;
		REQ_VALID = 1'b0;
		REQ_WRITE = 1'b0;
		REQ_INDEX = 16'h0000;
		REQ_SUBINDEX = 8'h00;
		REQ_WDATA = 32'h00000000;
		IN_PDO_DATA = 32'h00000000;
		nv_delay = 8'h00;
		seed = 32'h00004ce4;
		error_cnt = 0;
		samples_checked = 0;
		repeat (3) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		acc(1'b1, IDX_IDENT, 8'h00, xs());
		chk32(got, ABORT_READ_ONLY);
		acc(1'b0, IDX_IDENT, 8'h00, 32'h00000000);
		chk32(got, IDENT_VALUE);
		for (int j = 0; j < 4; j++) begin
			acc(1'(j), bad_i[j], bad_s[j], xs());
			chk32(got, bad_e[j]);
			chk1(ab, 1'b1);
		end
		for (int j = 0; j < 9; j++) begin
			r = xs();
			d = xs();
			ch = (j == 0) ? 6'h3f : r[13:8];
			nv_delay <= (j == 0) ? 8'h00 : (r[7:0] & 8'h0f);
			acc(1'b1, chidx(r[14] ? IDX_CH : IDX_OLD_CH, ch), {7'h00, ch[0]}, d);
			chk1(ab, 1'b0);
			idle();
			chk32({26'h0, last_addr}, {26'h0, ch});
			chk32(last_data, d);
			acc(1'b0, chidx(r[14] ? IDX_OLD_CH : IDX_CH, ch), {7'h00, ch[0]}, 32'h0);
			chk32(got, d);
		end
		nv_delay <= 8'd20;
		acc(1'b1, IDX_CH, 8'h00, xs());
		drive(1'b0, IDX_IDENT, 8'h00, 32'h0);
		chk1(RSP_VALID, 1'b0);
		chk1(BUSY, 1'b1);
		r = xs();
		@(posedge CLK_SYS);
		IN_PDO_DATA <= r;
		acc(1'b0, IDX_IN_PDO, 8'h00, 32'h0);
		chk32(got, r);
		acc(1'b1, IDX_IN_PDO, 8'h00, r);
		chk32(got, ABORT_READ_ONLY);
		c = commits;
		acc(1'b1, IDX_OUT_PDO, 8'h00, ~r);
		chk32(OUT_PDO_DATA, ~r);
		acc(1'b1, IDX_SAVE_CTL, 8'h00, SAVE_OFF_CODE);
		d = xs();
		acc(1'b1, 16'h8011, 8'h01, d);
		chk1(SUPPRESS_NONVOLATILE_SAVE, 1'b1);
		acc(1'b0, 16'h4011, 8'h01, 32'h0);
		chk32(got, d);
		chk32(commits, c);
		acc(1'b1, IDX_SAVE_CTL, 8'h00, SAVE_OFF_CODE + 32'h1);
		acc(1'b1, 16'h8011, 8'h01, d);
		chk1(SUPPRESS_NONVOLATILE_SAVE, 1'b0);
		idle();
		chk32(commits, c + 1);
		acc(1'b1, IDX_SAVE_CTL, 8'h00, SAVE_OFF_CODE);
		@(posedge CLK_SYS);
		RST_N <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		#1;
		chk1(SUPPRESS_NONVOLATILE_SAVE, 1'b0);
		c = commits;
		for (int j = 0; j < 3; j++) begin
			d = xs();
			acc(1'b1, IDX_CH + 16'(j), 8'h01, d);
			acc(1'b0, IDX_OLD_CH + 16'(j), 8'h01, 32'h0);
			chk32(got, d);
		end
		idle();
		chk32(commits, c + 3);
		end_of_test();
	end
endmodule

// ==== rtl/pds_nv_commit.sv ====
// Purpose: Hands a committed parameter to the nonvolatile writer
// Assumes: Writer acknowledges each request with NV_DONE
// Notes: Holds one pending commit at a time
`timescale 1ns/1ps
module pds_nv_commit
	import pds_pkg::*;
#(
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [AW-1:0] addr,
	input wire logic [pds_pkg::DAT_W-1:0] data,
	input wire logic done,
	output logic busy,
	output logic req,
	output logic [AW-1:0] req_addr,
	output logic [pds_pkg::DAT_W-1:0] req_data
);
	logic req_d;
	logic [AW-1:0] addr_d;
	logic [DAT_W-1:0] data_d;
	// ==========================================
	// Request hold
	always_comb begin
		req_d = req;
		addr_d = req_addr;
		data_d = req_data;
		if (req && done) begin
			req_d = 1'b0;
		end
		if (start && !req) begin
			req_d = 1'b1;
			addr_d = addr;
			data_d = data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req <= 1'b0;
			req_addr <= '0;
			req_data <= '0;
		end else begin
			req <= req_d;
			req_addr <= addr_d;
			req_data <= data_d;
		end
	end
	assign busy = req;
	AST_COMMIT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		req && !done |=> req && $stable(req_addr) && $stable(req_data))
		else $error("commit request dropped before acknowledge");
endmodule

// ==== rtl/pds_pkg.sv ====
// Purpose: Constants for the parameter dictionary store
// Assumes: One clock, asynchronous active-low reset
// Notes: Behaviour list below
//
// Behaviour
// - Entries addressed by 16-bit index and 8-bit subindex.
// - Access follows entry attribute; fixed entries read only.
// - Identity entry lives at index 0x1000.
// - Channel settings live from index 0x8000.
// - Old range 0x4000 mirrors 0x8000; both reach same storage.
// - Input PDOs at 0x6000, output PDOs at 0x7000.
// - Online writes are committed to nonvolatile memory safely.
// - Code word 0x12345678 at 0xF008 suppresses saving while held.
// - Suppressed writes are accepted but not saved; off after power-up.
// - Each channel owns sixteen indices, stride 0x10.
package pds_pkg;
	// ==========================================
	// Addressing
	localparam int IDX_W = 16;
	localparam int SUB_W = 8;
	localparam int DAT_W = 32;
	// Range select nibble width, channel field position and indices per channel
	localparam int SEL_W = 4;
	localparam int CH_LSB = 4;
	localparam int CH_STRIDE = 16;
	localparam logic [IDX_W-1:0] IDX_IDENT = 16'h1000;
	localparam logic [IDX_W-1:0] IDX_OLD_CH = 16'h4000;
	localparam logic [IDX_W-1:0] IDX_IN_PDO = 16'h6000;
	localparam logic [IDX_W-1:0] IDX_OUT_PDO = 16'h7000;
	localparam logic [IDX_W-1:0] IDX_CH = 16'h8000;
	localparam logic [IDX_W-1:0] IDX_SAVE_CTL = 16'hf008;
	localparam logic [3:0] RANGE_SEL_IDENT = 4'h1;
	localparam logic [3:0] RANGE_SEL_OLD = 4'h4;
	localparam logic [3:0] RANGE_SEL_IN = 4'h6;
	localparam logic [3:0] RANGE_SEL_OUT = 4'h7;
	localparam logic [3:0] RANGE_SEL_CH = 4'h8;
	localparam logic [DAT_W-1:0] SAVE_OFF_CODE = 32'h12345678;
	localparam logic [DAT_W-1:0] DATA_ZERO = 32'h00000000;
	// ==========================================
	// Abort codes
	localparam logic [DAT_W-1:0] ABORT_READ_ONLY = 32'h06010002;
	localparam logic [DAT_W-1:0] ABORT_NO_OBJECT = 32'h06020000;
	localparam logic [DAT_W-1:0] ABORT_NO_SUB = 32'h06090011;
	// Arbitrary identity value
	localparam logic [DAT_W-1:0] IDENT_VALUE = 32'h00c0ffee;
endpackage

// ==== rtl/pds_store.sv ====
// Purpose: Parameter dictionary store with index/subindex access
// Assumes: Requests are one-cycle pulses; a request waits while BUSY
// Notes: Channel storage is CHANNELS x 16 indices x SUBS words
`timescale 1ns/1ps
module pds_store
	import pds_pkg::*;
#(
	parameter int CHANNELS = 2,
	parameter int SUBS = 2
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic REQ_VALID,
	input wire logic REQ_WRITE,
	input wire logic [pds_pkg::IDX_W-1:0] REQ_INDEX,
	input wire logic [pds_pkg::SUB_W-1:0] REQ_SUBINDEX,
	input wire logic [pds_pkg::DAT_W-1:0] REQ_WDATA,
	input wire logic [pds_pkg::DAT_W-1:0] IN_PDO_DATA,
	input wire logic NV_DONE,
	output logic RSP_VALID,
	output logic RSP_ABORT,
	output logic [pds_pkg::DAT_W-1:0] RSP_DATA,
	output logic BUSY,
	output logic SUPPRESS_NONVOLATILE_SAVE,
	output logic NV_REQ,
	output logic [$clog2(CHANNELS*16*SUBS)-1:0] NV_ADDR,
	output logic [pds_pkg::DAT_W-1:0] NV_DATA,
	output logic [pds_pkg::DAT_W-1:0] OUT_PDO_DATA
);
	localparam int ENTRIES = CHANNELS * CH_STRIDE * SUBS;
	localparam int AW = $clog2(ENTRIES);
	localparam int SW = $clog2(SUBS);
	localparam int CHW = $clog2(CHANNELS);

	logic [DAT_W-1:0] mem_q [ENTRIES];
	logic [DAT_W-1:0] save_word_q, save_word_d;
	logic [DAT_W-1:0] out_pdo_q, out_pdo_d;
	logic rsp_valid_d, rsp_abort_d;
	logic [DAT_W-1:0] rsp_data_d;
	logic [SEL_W-1:0] sel;
	logic ch_hit, sub_ok, ch_wr, commit_start, nv_busy;
	logic [AW-1:0] ch_addr;

	// ==========================================
	// Decode
	function automatic logic save_word_q_eq(input logic [DAT_W-1:0] w);
		return w == SAVE_OFF_CODE;
	endfunction

	assign sel = REQ_INDEX[IDX_W-1 -: SEL_W];
	// Channel n owns indices base + n*0x10 .. +0xF; old range mirrors new
	assign ch_hit = (sel == RANGE_SEL_CH || sel == RANGE_SEL_OLD)
		&& (REQ_INDEX[IDX_W-SEL_W-1:CH_LSB]
		< (IDX_W-SEL_W-CH_LSB)'(CHANNELS));
	assign sub_ok = REQ_SUBINDEX < SUB_W'(SUBS);
	assign ch_addr = AW'({REQ_INDEX[CH_LSB+CHW-1:CH_LSB], REQ_INDEX[CH_LSB-1:0],
		REQ_SUBINDEX[SW-1:0]});
	assign ch_wr = REQ_VALID && REQ_WRITE && ch_hit && sub_ok && !nv_busy;
	assign commit_start = ch_wr && !save_word_q_eq(save_word_q);

	// ==========================================
	// Access handling
	always_comb begin
		rsp_valid_d = REQ_VALID && !nv_busy;
		rsp_abort_d = 1'b0;
		rsp_data_d = DATA_ZERO;
		save_word_d = save_word_q;
		out_pdo_d = out_pdo_q;
		if (REQ_VALID && !nv_busy) begin
			if (ch_hit) begin
				if (!sub_ok) begin
					rsp_abort_d = 1'b1;
					rsp_data_d = ABORT_NO_SUB;
				end else if (!REQ_WRITE) begin
					rsp_data_d = mem_q[ch_addr];
				end
			end else if (REQ_INDEX == IDX_IDENT && REQ_SUBINDEX == '0) begin
				if (REQ_WRITE) begin
					rsp_abort_d = 1'b1;
					rsp_data_d = ABORT_READ_ONLY;
				end else begin
					rsp_data_d = IDENT_VALUE;
				end
			end else if (REQ_INDEX == IDX_IN_PDO && REQ_SUBINDEX == '0) begin
				if (REQ_WRITE) begin
					rsp_abort_d = 1'b1;
					rsp_data_d = ABORT_READ_ONLY;
				end else begin
					rsp_data_d = IN_PDO_DATA;
				end
			end else if (REQ_INDEX == IDX_OUT_PDO && REQ_SUBINDEX == '0) begin
				if (REQ_WRITE) begin
					out_pdo_d = REQ_WDATA;
				end else begin
					rsp_data_d = out_pdo_q;
				end
			end else if (REQ_INDEX == IDX_SAVE_CTL && REQ_SUBINDEX == '0) begin
				if (REQ_WRITE) begin
					save_word_d = REQ_WDATA;
				end else begin
					rsp_data_d = save_word_q;
				end
			end else begin
				rsp_abort_d = 1'b1;
				rsp_data_d = ABORT_NO_OBJECT;
			end
		end
	end
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			RSP_VALID <= 1'b0;
			RSP_ABORT <= 1'b0;
			RSP_DATA <= DATA_ZERO;
			save_word_q <= DATA_ZERO;
			out_pdo_q <= DATA_ZERO;
		end else begin
			RSP_VALID <= rsp_valid_d;
			RSP_ABORT <= rsp_abort_d;
			RSP_DATA <= rsp_data_d;
			save_word_q <= save_word_d;
			out_pdo_q <= out_pdo_d;
		end
	end

	// ==========================================
	// Channel storage
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_ent
			always_ff @(posedge CLK_SYS or negedge RST_N) begin
				if (!RST_N) begin
					mem_q[gi] <= DATA_ZERO;
				end else if (ch_wr && ch_addr == AW'(gi)) begin
					mem_q[gi] <= REQ_WDATA;
				end
			end
		end
	endgenerate

	// ==========================================
	// Nonvolatile commit
	pds_nv_commit #(.AW(AW)) u_commit (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.start(commit_start),
		.addr(ch_addr),
		.data(REQ_WDATA),
		.done(NV_DONE),
		.busy(nv_busy),
		.req(NV_REQ),
		.req_addr(NV_ADDR),
		.req_data(NV_DATA)
	);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			SUPPRESS_NONVOLATILE_SAVE <= 1'b0;
			BUSY <= 1'b0;
			OUT_PDO_DATA <= DATA_ZERO;
		end else begin
			SUPPRESS_NONVOLATILE_SAVE <= save_word_d == SAVE_OFF_CODE;
			BUSY <= commit_start || (nv_busy && !NV_DONE);
			OUT_PDO_DATA <= out_pdo_d;
		end
	end

	// ==========================================
	// Checks
	sequence s_chan_write;
		REQ_VALID && REQ_WRITE && ch_hit && sub_ok && !nv_busy;
	endsequence
	sequence s_chan_read;
		REQ_VALID && !REQ_WRITE && ch_hit && sub_ok && !nv_busy;
	endsequence
	sequence s_ctl_write;
		REQ_VALID && REQ_WRITE && !nv_busy && REQ_INDEX == IDX_SAVE_CTL && REQ_SUBINDEX == '0;
	endsequence
	sequence s_ident_req;
		REQ_VALID && !nv_busy && REQ_INDEX == IDX_IDENT && REQ_SUBINDEX == '0;
	endsequence
	AST_SAVE_COMMIT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_chan_write ##0 !save_word_q_eq(save_word_q) |=> NV_REQ)
		else $error("write was not committed");
	AST_COMMIT_WORD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_chan_write ##0 !save_word_q_eq(save_word_q)
		|=> NV_ADDR == $past(ch_addr) && NV_DATA == $past(REQ_WDATA))
		else $error("commit carries wrong entry");
	AST_SAVE_SUPPRESS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_chan_write ##0 save_word_q_eq(save_word_q) && !NV_REQ |=> !NV_REQ)
		else $error("write committed while suppressed");
	AST_SUPPRESS_FLAG: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_ctl_write |=> SUPPRESS_NONVOLATILE_SAVE == ($past(REQ_WDATA) == SAVE_OFF_CODE))
		else $error("code word did not set suppression");
	AST_SUPPRESS_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		SUPPRESS_NONVOLATILE_SAVE
		&& !(REQ_VALID && REQ_WRITE && REQ_INDEX == IDX_SAVE_CTL) |=> SUPPRESS_NONVOLATILE_SAVE)
		else $error("suppression dropped while code word held");
	AST_READ_ONLY: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_ident_req ##0 REQ_WRITE |=> RSP_VALID && RSP_ABORT && RSP_DATA == ABORT_READ_ONLY)
		else $error("read-only write not aborted");
	AST_NO_COMMIT_OTHER: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		REQ_VALID && REQ_WRITE && !(ch_hit && sub_ok) && !nv_busy |=> !NV_REQ)
		else $error("non-channel write committed");
	AST_BAD_INDEX: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		REQ_VALID && !nv_busy && REQ_INDEX == '1 |=> RSP_ABORT && RSP_DATA == ABORT_NO_OBJECT)
		else $error("missing index not aborted");
	AST_BAD_SUB: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		REQ_VALID && !nv_busy && ch_hit && !sub_ok |=> RSP_ABORT && RSP_DATA == ABORT_NO_SUB)
		else $error("missing subindex not aborted");
	AST_MIRROR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_chan_write |=> mem_q[$past(ch_addr)] == $past(REQ_WDATA))
		else $error("channel write did not land");
	AST_CH_READ: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_chan_read |=> RSP_VALID && !RSP_ABORT && RSP_DATA == $past(mem_q[ch_addr]))
		else $error("channel read mismatch");
	AST_IDENT_READ: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_ident_req ##0 !REQ_WRITE |=> RSP_DATA == IDENT_VALUE && !RSP_ABORT)
		else $error("identity read wrong");
	AST_ANSWER: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		REQ_VALID && !nv_busy |=> RSP_VALID)
		else $error("accepted request not answered");
	AST_BUSY_NO_RSP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		REQ_VALID && nv_busy |=> !RSP_VALID)
		else $error("request answered while commit pending");
	AST_COMMIT_END: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		NV_REQ && NV_DONE |=> !NV_REQ && !BUSY)
		else $error("commit not released after acknowledge");
endmodule
